// File: rtl/fpb_debounce.sv
// Synchroniser plus stable-time filter for test inputs and buttons
`timescale 1ns/10ps
module fpb_debounce #(
  parameter int           W       = 1,
  parameter int           CYCLES  = 1000,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] clean_out
);

  logic [W-1:0] sync_w;
  logic [15:0]  cnt_ff;
  logic         done_w;

  fpb_sync2 #(.W(W), .RST_VAL(RST_VAL)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (raw_in),
    .q_out  (sync_w)
  );

  assign done_w = (cnt_ff == 16'(CYCLES - 1));

  // All bits share one count: a change must hold until the window already running ends; only a full return to clean_out restarts the count
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cnt_ff    <= '0;
      clean_out <= RST_VAL;
    end
    else if (sync_w == clean_out)
      cnt_ff <= '0;
    else if (done_w)
    begin
      cnt_ff    <= '0;
      clean_out <= sync_w;
    end
    else
      cnt_ff <= cnt_ff + 16'h0001;
  end

endmodule : fpb_debounce

// File: rtl/fpb_panel.sv
// Front panel bus control: run/stop, breakpoint latch, bus strobes and lamps
//
// Operation
// RULE1: Clear button empties the breakpoint latch; it sets again if breakpoint persists.
// RULE2: Bus valid flag marks stable buses, derivation picked by three options.
// RULE3: Wait lamp shows wait high, or line 3 or wait low.
// RULE4: Merge option keeps single-step and sense-disable apart or drives both together.
// RULE5: Second lamp shows interrupt low or error/stack high.
// RULE6: Bypass option disables all breakpoint logic and its controls.
// RULE7: Third lamp shows interrupt-enable high or phantom high.
// RULE8: Examine reaches target by jump opcode or by repeated no-ops.
// RULE9: Sense disable is input status and port match, optionally with data-in.
// RULE10: Run-force low returns to run unless some stop source is active.
// RULE11: Stop-force low sets stop; a single pulse keeps the processor stopped. The code returns to run after the pulse while the run/stop switch is raised.
// RULE12: Spare inverter outputs the complement of its pulled-up input.
// RULE13: Breakpoint test output follows data or address breakpoint by selector.
// RULE14: Latched test output goes high on capture, holds until cleared.
// RULE15: Breakpoint-enable low disables the address and data breakpoint.
// RULE16: Ready line low requests wait states, high lets the processor go.
// RULE17: Single-step pulls low while panel drives data, never in run. With the merge option the code also pulls it in run on a sense request.
// RULE18: Sense disable pulls low on sense port input; panel supplies switch byte.
// RULE19: Memory write pulses from deposit functions, inhibited in run.
// RULE20: Memory write also follows processor write strobe while output status low.
// RULE21: Run line is high in run and low in stop.
// RULE22: Breakpoint pulls ready low; sequencer override drives it high.
// RULE23: Latch sets if breakpoint low at bus-valid rise; stop follows next cycle.
// RULE24: Power-on clear low forces stop.
// RULE25: Switch stop takes effect only when fetch, sync and phase one high.
// RULE26: Test inputs and buttons are synchronised and debounced before use.
`timescale 1ns/10ps
module fpb_panel
  import fpb_pkg::*;
#(
  parameter int DEB_CYC = fpb_pkg::DEB_CYCLES
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire fpb_pkg::fpb_bus_t  bus_in,
  input  wire fpb_pkg::fpb_opt_t  opt_in,
  input  wire fpb_pkg::fpb_test_t test_in,
  input  wire logic              spare_inv_in,
  input  wire logic [7:0]        programmed_input_switches_in,
  input  wire logic [7:0]        panel_data_in,
  input  wire logic              seq_run_override_in,
  input  wire logic              seq_drive_data_in,
  input  wire logic              seq_deposit_in,
  output logic                   xrdy_n_out,
  output logic                   ss_n_out,
  output logic                   ss_oe_out,
  output logic                   ssw_dsb_n_out,
  output logic                   ssw_dsb_oe_out,
  output logic                   mwrite_out,
  output logic                   run_out,
  output logic [7:0]             data_out,
  output logic                   data_oe_out,
  output logic [7:0]             examine_opcode_out,
  output logic                   bus_valid_flag_out,
  output logic                   bp_test_out,
  output logic                   bp_latched_out,
  output logic                   spare_inv_out,
  output logic                   wait_indicator_lamp_out,
  output logic                   second_indicator_lamp_out,
  output logic                   third_indicator_lamp_out,
  output logic                   latch_indicator_lamp_out
);

  import fpb_pkg::*;

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  fpb_bus_t  bus_s;
  fpb_opt_t  opt_s;
  fpb_test_t test_s;
  logic      spare_s;

  // Backplane levels come from another clock, so two stages first
  fpb_sync2 #(.W($bits(fpb_bus_t)), .RST_VAL('1)) u_bus_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (bus_in),
    .q_out  (bus_s)
  );

  fpb_sync2 #(.W($bits(fpb_opt_t)), .RST_VAL('0)) u_opt_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (opt_in),
    .q_out  (opt_s)
  );

  fpb_sync2 #(.W(1), .RST_VAL(PULLUP_LEVEL)) u_spare_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (spare_inv_in),
    .q_out  (spare_s)
  );

  // Contact bounce would toggle run/stop, hence the filter
  fpb_debounce #(.W($bits(fpb_test_t)), .CYCLES(DEB_CYC), .RST_VAL(TEST_RST)) u_test_deb ( // RULE26
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .raw_in    (test_in),
    .clean_out (test_s)
  );

  // ****************************************************************
  // Bus valid flag
  // ****************************************************************
  logic bv_base_w;
  logic bv_w;
  logic bv_prev_ff;
  logic bv_rise_w;

  // Different processor boards settle at different points of the cycle
  assign bv_base_w = opt_s.bus_valid_timing_option_a ? bus_s.dbin : (bus_s.dbin | ~bus_s.pwr_n); // RULE2
  assign bv_w      = bv_base_w & ~(opt_s.bus_valid_timing_option_b & bus_s.psync)
                     & (~opt_s.bus_valid_timing_option_c | bus_s.phi2);                      // RULE2
  assign bv_rise_w = bv_w & ~bv_prev_ff;

  // ****************************************************************
  // Breakpoint path
  // ****************************************************************
  logic bypass_w;
  logic bp_sel_n_w;
  logic bp_act_w;
  logic latch_ff;
  logic latch_set_w;
  logic latch_clr_w;
  logic nxt_latch;

  assign bypass_w    = opt_s.breakpoint_bypass_option;                                        // RULE6
  assign bp_sel_n_w  = opt_s.breakpoint_source_selector ? bus_s.data_bp_n : bus_s.addr_bp_n; // RULE13
  assign bp_act_w    = ~bp_sel_n_w & test_s.bp_enable & ~bypass_w;                          // RULE15
  assign latch_set_w = bv_rise_w & bp_act_w;                                                 // RULE23
  assign latch_clr_w = ~test_s.latch_clear_button_n | bypass_w;                             // RULE1
  // Set wins over clear, so a persisting breakpoint relights the lamp
  assign nxt_latch   = latch_set_w | (latch_ff & ~latch_clr_w);                             // RULE1

  // ****************************************************************
  // Run/stop flip-flop
  // ****************************************************************
  fpb_run_t run_ff;
  fpb_run_t nxt_run;
  logic     fetch_w;
  logic     stop_src_w;
  logic     sw_stop_w;

  assign fetch_w    = bus_s.m1 & bus_s.psync & bus_s.phi1;                                   // RULE25
  assign sw_stop_w  = ~test_s.run_stop_switch & fetch_w;                                     // RULE25
  assign stop_src_w = ~bus_s.poc_n | ~test_s.stop_force_n | sw_stop_w;                      // RULE24

  // Stop sources dominate; run-force and the raised switch only release
  always_comb
  begin
    nxt_run = run_ff;
    if (stop_src_w)
      nxt_run = FPB_STOP;                                                                    // RULE11
    else if (!test_s.run_force_n && test_s.run_stop_switch)
      nxt_run = FPB_RUN;                                                                     // RULE10
    else if (!test_s.run_force_n)
      nxt_run = FPB_RUN; // RULE10
    else if (test_s.run_stop_switch)
      nxt_run = FPB_RUN;
    else
      nxt_run = run_ff;
  end

  // ****************************************************************
  // Bus strobes and data
  // ****************************************************************
  logic is_run_w;
  logic nxt_xrdy_n;
  logic nxt_ss;
  logic nxt_dsb;
  logic dsb_req_w;
  logic panel_req_w;
  logic nxt_mwrite;

  assign is_run_w    = (run_ff == FPB_RUN);
  // Stop or a live breakpoint holds ready low; the sequencer may overrule both
  assign nxt_xrdy_n  = seq_run_override_in | (is_run_w & ~bp_act_w & ~latch_ff);           // RULE16 RULE22
  assign dsb_req_w   = bus_s.sinp & bus_s.port_match
                       & (~opt_s.input_disable_definition_option | bus_s.dbin);             // RULE9
  assign panel_req_w = seq_drive_data_in & ~is_run_w;                                        // RULE17
  assign nxt_ss      = panel_req_w | (opt_s.signal_merge_option & dsb_req_w);               // RULE4
  assign nxt_dsb     = dsb_req_w | (opt_s.signal_merge_option & panel_req_w);               // RULE4 RULE18
  assign nxt_mwrite  = (seq_deposit_in & ~is_run_w) | (~bus_s.pwr_n & ~bus_s.sout);         // RULE19 RULE20

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      run_ff     <= FPB_STOP;
      latch_ff   <= 1'b0;
      bv_prev_ff <= 1'b0;
    end
    else
    begin
      run_ff     <= nxt_run;
      latch_ff   <= nxt_latch;                                                               // RULE23
      bv_prev_ff <= bv_w;
    end
  end

  // Bus strobes; open-collector lines only ever pull low
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      xrdy_n_out     <= 1'b0;
      ss_n_out       <= 1'b0;
      ss_oe_out      <= 1'b0;
      ssw_dsb_n_out  <= 1'b0;
      ssw_dsb_oe_out <= 1'b0;
      mwrite_out     <= 1'b0;
      run_out        <= 1'b0;
      data_out       <= 8'h00;
      data_oe_out    <= 1'b0;
    end
    else
    begin
      xrdy_n_out     <= nxt_xrdy_n;                                                          // RULE16
      ss_n_out       <= 1'b0;
      ss_oe_out      <= nxt_ss;                                                              // RULE17
      ssw_dsb_n_out  <= 1'b0;
      ssw_dsb_oe_out <= nxt_dsb;                                                             // RULE18
      mwrite_out     <= nxt_mwrite;
      run_out        <= is_run_w;                                                            // RULE21
      data_out       <= dsb_req_w ? programmed_input_switches_in : panel_data_in;           // RULE18
      data_oe_out    <= dsb_req_w | panel_req_w;
    end
  end

  // Lamps and test points
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      examine_opcode_out        <= OP_JUMP;
      bus_valid_flag_out        <= 1'b0;
      bp_test_out               <= 1'b1;
      bp_latched_out            <= 1'b0;
      spare_inv_out             <= ~PULLUP_LEVEL;
      wait_indicator_lamp_out   <= LAMP_OFF;
      second_indicator_lamp_out <= LAMP_OFF;
      third_indicator_lamp_out  <= LAMP_OFF;
      latch_indicator_lamp_out  <= LAMP_OFF;
    end
    else
    begin
      examine_opcode_out        <= opt_s.examine_style_option ? OP_NOP : OP_JUMP;           // RULE8
      bus_valid_flag_out        <= bv_w;                                                     // RULE2
      bp_test_out               <= ~bp_act_w;                                                // RULE13
      bp_latched_out            <= latch_ff;                                                 // RULE14
      spare_inv_out             <= ~spare_s;                                                 // RULE12
      wait_indicator_lamp_out   <= opt_s.wait_lamp_source_option
                                   ? (~bus_s.xrdy_level | ~bus_s.wait_hi) : bus_s.wait_hi;  // RULE3
      second_indicator_lamp_out <= opt_s.second_lamp_source_option
                                   ? bus_s.err_stack : ~bus_s.int_n;                         // RULE5
      third_indicator_lamp_out  <= opt_s.third_lamp_source_option
                                   ? bus_s.phantom_n : bus_s.inte;                           // RULE7
      latch_indicator_lamp_out  <= latch_ff;                                                 // RULE1
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_poc_stop: assert property (!bus_s.poc_n |=> run_ff == FPB_STOP ##1 !run_out) // RULE24
    else $error("power-on clear did not stop");
  a_stop_force: assert property (!test_s.stop_force_n |=> !is_run_w ##1 !xrdy_n_out || $past(seq_run_override_in)) // RULE11
    else $error("stop force ignored");
  a_run_force: assert property (!test_s.run_force_n && !stop_src_w |=> is_run_w) // RULE10
    else $error("run force ignored");
  a_switch_fetch: assert property (is_run_w && !test_s.run_stop_switch && !fetch_w && bus_s.poc_n
                                   && test_s.stop_force_n |=> is_run_w) // RULE25
    else $error("switch stopped outside fetch");
  a_latch_set: assert property (latch_set_w |=> latch_ff ##1 bp_latched_out && latch_indicator_lamp_out) // RULE23
    else $error("breakpoint not latched");
  a_latch_clear: assert property (latch_ff && latch_clr_w && !latch_set_w |=> !latch_ff) // RULE1
    else $error("latch not cleared");
  a_bypass_quiet: assert property (bypass_w |=> !latch_ff && bp_test_out) // RULE6
    else $error("breakpoint active while bypassed");
  a_ss_idle_run: assert property (run_out && !ssw_dsb_oe_out |-> !ss_oe_out) // RULE17
    else $error("single-step driven in run");
  a_mwrite_pwr: assert property (!bus_s.pwr_n && !bus_s.sout |=> mwrite_out) // RULE20
    else $error("processor write not echoed");
  a_spare_inv: assert property (##1 spare_inv_out == !$past(spare_s)) // RULE12
    else $error("spare inverter wrong");
  a_ready_stop: assert property (!is_run_w && !seq_run_override_in |=> !xrdy_n_out) // RULE16
    else $error("ready released in stop");

  // Ready line: run releases it, a breakpoint pulls it, the sequencer overrules both
  a_ready_run: assert property ( // RULE16
      is_run_w && !bp_act_w && !latch_ff |=> xrdy_n_out)
    else $error("ready held low in run");
  a_bp_stop: assert property ( // RULE22
      bp_act_w && !seq_run_override_in |=> !xrdy_n_out)
    else $error("breakpoint did not stop");
  a_seq_override: assert property ( // RULE22
      seq_run_override_in |=> xrdy_n_out)
    else $error("override did not release ready");

  // Run line, strobes, the sense byte and the examine opcode
  a_run_line: assert property ( // RULE21
      ##1 run_out == $past(is_run_w))
    else $error("run line wrong");
  a_mwrite_run: assert property ( // RULE19
      is_run_w && (bus_s.pwr_n || bus_s.sout) |=> !mwrite_out)
    else $error("deposit write in run");
  a_ss_run: assert property ( // RULE17
      is_run_w && !(opt_s.signal_merge_option && dsb_req_w) |=> !ss_oe_out)
    else $error("single-step pulled in run");
  a_merge_apart: assert property ( // RULE4
      !opt_s.signal_merge_option && !panel_req_w |=> !ss_oe_out)
    else $error("single-step pulled while unmerged");
  a_sense_byte: assert property ( // RULE18
      dsb_req_w |=> ssw_dsb_oe_out && data_oe_out
      && data_out == $past(programmed_input_switches_in))
    else $error("sense byte not driven");
  a_opcode_pick: assert property ( // RULE8
      ##1 examine_opcode_out == ($past(opt_s.examine_style_option) ? OP_NOP : OP_JUMP))
    else $error("examine opcode wrong");

  // Breakpoint enable, latch hold and its lamp
  a_bp_enable: assert property ( // RULE15
      !test_s.bp_enable |=> bp_test_out)
    else $error("breakpoint enable ignored");
  a_latch_hold: assert property ( // RULE14
      latch_ff && !latch_clr_w |=> latch_ff)
    else $error("latch dropped without clear");
  a_latch_lamp: assert property ( // RULE1
      ##1 latch_indicator_lamp_out == $past(latch_ff))
    else $error("latch lamp wrong");

  c_stop_run: cover property (!is_run_w ##1 is_run_w);
  c_latch_hit: cover property (latch_set_w ##1 latch_ff ##[1:50] !latch_ff);
  c_sense_in: cover property (dsb_req_w ##1 ssw_dsb_oe_out && data_oe_out);
  c_override: cover property (seq_run_override_in && !is_run_w ##1 xrdy_n_out);
  c_merge_drive: cover property (opt_s.signal_merge_option && dsb_req_w ##1 ss_oe_out);

endmodule : fpb_panel

// File: rtl/fpb_pkg.sv
// Shared constants and carrier types of the front panel bus control block
package fpb_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ      = 50_000_000;
  localparam int DEB_TIME_NS = 20_000;
  // Least time rounds up to whole cycles
  localparam int DEB_CYCLES  = (DEB_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [7:0] OP_JUMP      = 8'hc3;
  localparam logic [7:0] OP_NOP       = 8'h00;
  localparam logic       PULLUP_LEVEL = 1'b1;
  localparam logic       LAMP_OFF     = 1'b0;

  // Run/stop flip-flop; one bit, so the encoding is Gray already
  typedef enum logic {
    FPB_STOP = 1'b0,
    FPB_RUN  = 1'b1
  } fpb_run_t;

  // Backplane levels as seen on the pins
  typedef struct packed {
    logic wait_hi;       // Line 27
    logic xrdy_level;    // Line 3 read back
    logic int_n;         // Line 73
    logic err_stack;     // Line 98
    logic inte;          // Line 28
    logic phantom_n;     // Line 67
    logic m1;
    logic psync;
    logic phi1;
    logic phi2;
    logic sinp;
    logic sout;          // Line 45
    logic dbin;
    logic pwr_n;         // Line 77
    logic poc_n;         // Line 99
    logic port_match;    // Port address equals the sense port
    logic data_bp_n;     // Data comparator, active low
    logic addr_bp_n;     // Address comparator, active low
  } fpb_bus_t;

  // Jumper and switch straps
  typedef struct packed {
    logic bus_valid_timing_option_a;
    logic bus_valid_timing_option_b;
    logic bus_valid_timing_option_c;
    logic wait_lamp_source_option;
    logic signal_merge_option;
    logic second_lamp_source_option;
    logic breakpoint_bypass_option;
    logic third_lamp_source_option;
    logic examine_style_option;
    logic input_disable_definition_option;
    logic breakpoint_source_selector;   // 1 = data, 0 = address
  } fpb_opt_t;

  // Test points and buttons, all pulled high when open
  typedef struct packed {
    logic run_force_n;
    logic stop_force_n;
    logic bp_enable;
    logic latch_clear_button_n;
    logic run_stop_switch;              // 1 = run position
  } fpb_test_t;

  localparam fpb_test_t TEST_RST = '{default: PULLUP_LEVEL};

endpackage : fpb_pkg

// File: rtl/fpb_sync2.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/10ps
module fpb_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_ff <= RST_VAL;
      q_out   <= RST_VAL;
    end
    else
    begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule : fpb_sync2

// File: sim/fpb_cpu_model.sv
// Backplane partner: processor machine-cycle stepper that obeys the ready line
`timescale 1ns/10ps
module fpb_cpu_model
  import fpb_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              en_in,
  input  wire logic              xrdy_n_in,
  input  wire fpb_pkg::fpb_bus_t stat_in,
  output fpb_pkg::fpb_bus_t      bus_out
);
  // ********
  // Cycle stepper
  // ********
  logic [2:0] ph_ff = 3'h0;

  // Holds in the fourth state (ph_ff 3) while ready is low, like a real wait state
  always_ff @(posedge clk_in)
  begin
    if (!(ph_ff == 3'h3 && !xrdy_n_in))
    begin
      ph_ff <= ph_ff + 3'h1;
    end
  end

  // Fetch-only traffic; when disabled the bench owns every line
  always_comb
  begin
    bus_out = stat_in;
    if (en_in)
    begin
      bus_out.phi1  = !ph_ff[0];
      bus_out.phi2  = ph_ff[0];
      bus_out.psync = (ph_ff[2:1] == 2'h0);
      bus_out.m1    = 1'b1;
      bus_out.dbin  = (ph_ff[2:1] == 2'h2);
    end
  end
endmodule : fpb_cpu_model

// File: sim/tb.sv
// Self-checking bench for the front panel bus control block
`timescale 1ns/10ps
module tb;
  import fpb_pkg::*;
  // ********
  // Stimulus and wiring
  // ********
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  fpb_bus_t   stat, bus;
  fpb_opt_t   opt;
  fpb_test_t  tst;
  logic       spare, ovr, drv, dep, en;
  logic [7:0] sw, pdat, dout, opc;
  logic       xrdy_n, ss_oe, dsb_oe, mwr, run, bv, bpt, bpl, sinv, l1, l2, l3, l4, doe, ssn, dsbn;
  int         num_errors = 0;
  int         checks_done = 0;
  int         j;

  always #10 clk_in = ~clk_in;

  fpb_cpu_model i_cpu (.clk_in(clk_in), .en_in(en), .xrdy_n_in(xrdy_n), .stat_in(stat), .bus_out(bus));

  // Small debounce count keeps the run short
  fpb_panel #(.DEB_CYC(4)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .opt_in(opt), .test_in(tst),
    .spare_inv_in(spare), .programmed_input_switches_in(sw), .panel_data_in(pdat),
    .seq_run_override_in(ovr), .seq_drive_data_in(drv), .seq_deposit_in(dep),
    .xrdy_n_out(xrdy_n), .ss_n_out(ssn), .ss_oe_out(ss_oe), .ssw_dsb_n_out(dsbn), .ssw_dsb_oe_out(dsb_oe),
    .mwrite_out(mwr), .run_out(run), .data_out(dout), .data_oe_out(doe), .examine_opcode_out(opc),
    .bus_valid_flag_out(bv), .bp_test_out(bpt), .bp_latched_out(bpl), .spare_inv_out(sinv),
    .wait_indicator_lamp_out(l1), .second_indicator_lamp_out(l2), .third_indicator_lamp_out(l3),
    .latch_indicator_lamp_out(l4));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Sample a quarter cycle after the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask : tick

  // Low pulse on a test input: 0 run force, 1 stop force, 2 latch clear
  task automatic pulse(input int k);
    @(posedge clk_in);
    tst.run_force_n <= (k != 0);
    tst.stop_force_n <= (k != 1);
    tst.latch_clear_button_n <= (k != 2);
    repeat (10) @(posedge clk_in);
    tst.run_force_n <= 1'b1;
    tst.stop_force_n <= 1'b1;
    tst.latch_clear_button_n <= 1'b1;
    tick(15);
  endtask : pulse

  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // Generous bound: the sequence needs about 870 cycles
  initial
  begin
    #400000;
    num_errors++;
    report_and_stop();
  end

  // ********
  // Test sequence
  // ********
  initial
  begin
    stat = 18'h0001b; // Write strobe, clear and comparators idle
    opt = '0;
    tst = TEST_RST;
    {spare, ovr, drv, dep, en, sw, pdat} = {5'h01, 16'h0000};
    tick(5);
    check(run, 1'b0);
    check(mwr, 1'b0);
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    drv <= 1'b1;
    dep <= 1'b1;
    tick(15);
    check(run, 1'b1);
    check(xrdy_n, 1'b1);
    check(ss_oe, 1'b0);
    check(mwr, 1'b0);
    @(posedge clk_in);
    drv <= 1'b0;
    dep <= 1'b0;
    en <= 1'b0;
    tst.run_stop_switch <= 1'b0;
    tick(15);
    check(run, 1'b1);
    pulse(1);
    check(run, 1'b0);
    check(xrdy_n, 1'b0);
    pulse(0);
    check(run, 1'b1);
    @(posedge clk_in);
    tst.run_force_n <= 1'b0;
    tst.stop_force_n <= 1'b0;
    tick(15);
    check(run, 1'b0);
    pulse(0);
    check(run, 1'b1);
    @(posedge clk_in);
    {stat.m1, stat.psync, stat.phi1} <= 3'h7;
    tick(8);
    check(run, 1'b0);
    @(posedge clk_in);
    {stat.m1, stat.psync, stat.phi1} <= 3'h0;
    pulse(0);
    @(posedge clk_in);
    tst.stop_force_n <= 1'b0;
    repeat (2) @(posedge clk_in);
    tst.stop_force_n <= 1'b1;
    tick(10);
    check(run, 1'b1);
    @(posedge clk_in);
    stat.poc_n <= 1'b0;
    tick(6);
    check(run, 1'b0);
    @(posedge clk_in);
    stat.poc_n <= 1'b1;
    pdat <= 8'h5a;
    drv <= 1'b1;
    tick(3);
    check(ss_oe, 1'b1);
    check(dout, 8'h5a);
    check(doe, 1'b1);
    check(ssn, 1'b0);
    @(posedge clk_in);
    drv <= 1'b0;
    dep <= 1'b1;
    tick(3);
    check(mwr, 1'b1);
    @(posedge clk_in);
    dep <= 1'b0;
    ovr <= 1'b1;
    tick(3);
    check(xrdy_n, 1'b1);
    @(posedge clk_in);
    ovr <= 1'b0;
    stat.pwr_n <= 1'b0;
    tick(6);
    check(mwr, 1'b1);
    @(posedge clk_in);
    stat.sout <= 1'b1;
    tick(6);
    check(mwr, 1'b0);
    @(posedge clk_in);
    {stat.pwr_n, stat.sout, stat.sinp, stat.port_match} <= 4'hb;
    sw <= 8'ha7;
    for (j = 0; j < 8; j++)
    begin
      @(posedge clk_in);
      opt.input_disable_definition_option <= j[0];
      stat.dbin <= j[1];
      opt.signal_merge_option <= j[2];
      tick(6);
      check(dsb_oe, !(j[0] && !j[1]));
      check(ss_oe, j[2] && !(j[0] && !j[1]));
      check(doe, !(j[0] && !j[1]));
      check(dsbn, 1'b0);
      if (!(j[0] && !j[1]))
      begin
        check(dout, 8'ha7);
      end
    end
    for (j = 0; j < 64; j++)
    begin
      @(posedge clk_in);
      opt.wait_lamp_source_option <= j[0];
      opt.second_lamp_source_option <= j[1];
      opt.third_lamp_source_option <= j[2];
      {stat.wait_hi, stat.xrdy_level, stat.int_n} <= {j[3], j[4], j[5]};
      {stat.err_stack, stat.inte, stat.phantom_n} <= {j[3] ^ j[4], j[4], j[5] ^ j[3]};
      tick(6);
      check(l1, j[0] ? !(j[4] && j[3]) : j[3]);
      check(l2, j[1] ? j[3] ^ j[4] : !j[5]);
      check(l3, j[2] ? j[5] ^ j[3] : j[4]);
    end
    for (j = 0; j < 2; j++)
    begin
      @(posedge clk_in);
      spare <= j[0];
      opt.examine_style_option <= j[0];
      tick(6);
      check(sinv, !j[0]);
      check(opc, j[0] ? OP_NOP : OP_JUMP);
    end
    // Breakpoint path, bus valid follows data-in alone with option a
    @(posedge clk_in);
    {stat.dbin, stat.sinp, stat.data_bp_n} <= 3'h0;
    opt.bus_valid_timing_option_a <= 1'b1;
    opt.breakpoint_source_selector <= 1'b1;
    tick(6);
    check(bpt, 1'b0);
    check(bv, 1'b0);
    @(posedge clk_in);
    opt.breakpoint_source_selector <= 1'b0;
    tick(6);
    check(bpt, 1'b1);
    @(posedge clk_in);
    stat.addr_bp_n <= 1'b0;
    tst.bp_enable <= 1'b0;
    tick(15);
    check(bpt, 1'b1);
    @(posedge clk_in);
    stat.addr_bp_n <= 1'b1;
    tst.bp_enable <= 1'b1;
    opt.breakpoint_source_selector <= 1'b1;
    tick(15);
    @(posedge clk_in);
    stat.dbin <= 1'b1;
    tick(6);
    check(bv, 1'b1);
    check(bpl, 1'b1);
    check(l4, 1'b1);
    @(posedge clk_in);
    {stat.dbin, stat.data_bp_n} <= 2'h1;
    tick(6);
    check(bpl, 1'b1);
    @(posedge clk_in);
    stat.data_bp_n <= 1'b0;
    pulse(2);
    check(bpl, 1'b0);
    check(l4, 1'b0);
    @(posedge clk_in);
    stat.dbin <= 1'b1;
    tick(6);
    check(bpl, 1'b1);
    @(posedge clk_in);
    opt.breakpoint_bypass_option <= 1'b1;
    stat.dbin <= 1'b0;
    tick(6);
    @(posedge clk_in);
    stat.dbin <= 1'b1;
    tick(6);
    check(bpl, 1'b0);
    @(posedge clk_in);
    opt.breakpoint_bypass_option <= 1'b0;
    pulse(0);
    check(run, 1'b1);
    check(xrdy_n, 1'b0);
    report_and_stop();
  end
endmodule : tb
